/* File: include/gsa_pkg.sv */
// Shared constants and types for the serial word alignment block.
package gsa_pkg;

  // Word geometry: one parallel word is ten serial bit times.
  localparam int WORD_W = 10;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] WORD_HALF = 4'h5;
  localparam logic [9:0] RX_ALL_ONES = 10'h3ff;

  // Comma pattern 0011111XXX, first received bit at index zero.
  localparam int COMMA_W = 7;
  localparam logic [6:0] COMMA_BITS = 7'h7c;

  // Loss-of-input threshold of the front-end comparator, in millivolts.
  localparam int SIG_THRESH_MV = 50;

  // Register bus geometry and map.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] RX_WORD_OFS = 8'h10;

  // Control register fields.
  localparam int CTRL_WRAP_BIT = 0;
  localparam int CTRL_ALIGN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register fields.
  localparam int STAT_PRESENT_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;

  // Interrupt status and mask fields.
  localparam int IRQ_W = 3;
  localparam int IRQ_COMMA_BIT = 0;
  localparam int IRQ_LOSS_BIT = 1;
  localparam int IRQ_GAIN_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Alignment state, one-hot.
  typedef enum logic [1:0] {
    ALN_FREE = 2'b01,
    ALN_LOCK = 2'b10
  } gsa_align_type;

  // Parallel receive word and its comma flag travel together.
  typedef struct packed {
    logic comma_found;
    logic [9:0] word;
  } gsa_rx_out_type;

endpackage

/* File: core/gsa_word_align.sv */
// Serializer control, receive word alignment and register slave of the gigabit link.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module gsa_word_align (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic din,
  input wire logic din_level_ok,
  input wire logic [9:0] tx_word,
  output logic tx_word_clk,
  output logic dout_p,
  output logic dout_n,
  output gsa_pkg::gsa_rx_out_type rx_out,
  output logic rx_byte_clk0,
  output logic rx_byte_clk1,
  output logic signal_present,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic link_s1_reg;
  logic link_s2_reg;
  logic link_s3_reg;
  logic din_s1_reg;
  logic din_s2_reg;
  logic lvl_s1_reg;
  logic lvl_s2_reg;
  logic bit_tick;

  logic serial_wrap_enable;
  logic comma_align_enable;
  logic [1:0] ctrl_reg;

  logic [3:0] tx_cnt_reg;
  logic [9:0] tx_sh_reg;
  logic [9:0] tx_sh_next;
  logic tx_word_clk_reg;
  logic dout_reg;
  logic dout_n_reg;
  logic tx_bit;

  logic rx_bit;
  logic [3:0] rx_cnt_reg;
  logic [9:0] rx_sh_reg;
  logic [9:0] rx_sh_next;
  logic comma_hit;
  logic comma_soon;
  logic word_done;
  gsa_pkg::gsa_rx_out_type rx_out_reg;
  logic byte_sel_reg;
  logic byte_sel_next;
  logic rx_clk0_reg;
  logic rx_clk1_reg;
  gsa_pkg::gsa_align_type align_reg;

  logic present_reg;
  logic loss_evt;
  logic gain_evt;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_stat_next;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic irq_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  // The link clock and the serial input are sampled together so that each
  // serial bit is taken with the same delay as the clock edge that marks it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_s1_reg <= 1'b0;
      link_s2_reg <= 1'b0;
      link_s3_reg <= 1'b0;
    end else begin
      link_s1_reg <= link_clk;
      link_s2_reg <= link_s1_reg;
      link_s3_reg <= link_s2_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din_s1_reg <= 1'b0;
      din_s2_reg <= 1'b0;
      lvl_s1_reg <= 1'b0;
      lvl_s2_reg <= 1'b0;
    end else begin
      din_s1_reg <= din;
      din_s2_reg <= din_s1_reg;
      lvl_s1_reg <= din_level_ok;
      lvl_s2_reg <= lvl_s1_reg;
    end
  end

  assign bit_tick = link_s2_reg & ~link_s3_reg;
  assign serial_wrap_enable = ctrl_reg[gsa_pkg::CTRL_WRAP_BIT];
  assign comma_align_enable = ctrl_reg[gsa_pkg::CTRL_ALIGN_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Transmit path.

  // The shift register itself is the input latch: a word is taken whole at
  // the rise of the word clock and then shifted out least significant first.
  always_comb begin
    if (tx_cnt_reg == gsa_pkg::BIT_LAST) begin
      tx_sh_next = tx_word;
    end else begin
      tx_sh_next = {1'b0, tx_sh_reg[9:1]};
    end
  end

  assign tx_bit = tx_sh_next[0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_cnt_reg <= gsa_pkg::BIT_LAST;
      tx_sh_reg <= '0;
      tx_word_clk_reg <= 1'b0;
    end else if (bit_tick) begin
      if (tx_cnt_reg == gsa_pkg::BIT_LAST) begin
        tx_cnt_reg <= '0;
      end else begin
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
      end
      tx_sh_reg <= tx_sh_next;
      tx_word_clk_reg <= (tx_cnt_reg == gsa_pkg::BIT_LAST) ||
                         (tx_cnt_reg < gsa_pkg::WORD_HALF - 4'h1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dout_reg <= 1'b1;
      dout_n_reg <= 1'b0;
    end else if (serial_wrap_enable) begin
      dout_reg <= 1'b1;
      dout_n_reg <= 1'b0;
    end else if (bit_tick) begin
      dout_reg <= tx_bit;
      dout_n_reg <= ~tx_bit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive path.

  assign rx_bit = serial_wrap_enable ? tx_bit : din_s2_reg;
  assign rx_sh_next = {rx_bit, rx_sh_reg[9:1]};
  // Only the seven leading bits identify the comma; the last three vary.
  assign comma_hit = comma_align_enable &&
                     (rx_sh_next[gsa_pkg::COMMA_W-1:0] == gsa_pkg::COMMA_BITS);
  // A comma closes the word at once, which moves the word boundary to it.
  assign word_done = bit_tick && (comma_hit || rx_cnt_reg == gsa_pkg::BIT_LAST);
  // A comma one bit from closing pulls byte clock one low first, so the comma
  // word always brings a true rising edge on it, even while realigning.
  assign comma_soon = bit_tick && comma_align_enable &&
                      (rx_sh_next[gsa_pkg::COMMA_W:1] == gsa_pkg::COMMA_BITS);
  assign byte_sel_next = comma_hit ? 1'b1 : (comma_soon ? 1'b0 : ~byte_sel_reg);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_cnt_reg <= '0;
      rx_sh_reg <= '0;
    end else if (bit_tick) begin
      rx_sh_reg <= rx_sh_next;
      if (word_done) begin
        rx_cnt_reg <= '0;
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_out_reg.word <= gsa_pkg::RX_ALL_ONES;
      rx_out_reg.comma_found <= 1'b0;
    end else begin
      if (!present_reg) begin
        rx_out_reg.word <= gsa_pkg::RX_ALL_ONES;
      end else if (word_done) begin
        rx_out_reg.word <= rx_sh_next;
      end
      if (!comma_align_enable) begin
        rx_out_reg.comma_found <= 1'b0;
      end else if (word_done) begin
        rx_out_reg.comma_found <= comma_hit;
      end
    end
  end

  // Both byte clocks switch together and are opposite from their first update on (reset holds both low); a word
  // boundary gives one rising edge, and a coming comma may swap them early.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      byte_sel_reg <= 1'b0;
      rx_clk0_reg <= 1'b0;
      rx_clk1_reg <= 1'b0;
    end else if (word_done || comma_soon) begin
      byte_sel_reg <= byte_sel_next;
      rx_clk1_reg <= byte_sel_next;
      rx_clk0_reg <= ~byte_sel_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      align_reg <= gsa_pkg::ALN_FREE;
    end else begin
      case (align_reg)
        gsa_pkg::ALN_FREE: begin
          if (word_done && comma_hit) begin
            align_reg <= gsa_pkg::ALN_LOCK;
          end
        end
        gsa_pkg::ALN_LOCK: begin
          if (!comma_align_enable || !present_reg) begin
            align_reg <= gsa_pkg::ALN_FREE;
          end
        end
        default: begin
          align_reg <= gsa_pkg::ALN_FREE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Signal presence.

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      present_reg <= 1'b0;
    end else begin
      present_reg <= lvl_s2_reg;
    end
  end

  assign loss_evt = present_reg & ~lvl_s2_reg;
  assign gain_evt = ~present_reg & lvl_s2_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Register slave and interrupt.

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= gsa_pkg::CTRL_RESET;
      irq_mask_reg <= gsa_pkg::IRQ_RESET;
    end else if (wr) begin
      if (addr == gsa_pkg::CTRL_OFS) begin
        ctrl_reg <= wdata[1:0];
      end
      if (addr == gsa_pkg::IRQ_MASK_OFS) begin
        irq_mask_reg <= wdata[gsa_pkg::IRQ_W-1:0];
      end
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[gsa_pkg::IRQ_COMMA_BIT] = word_done & comma_hit;
    irq_set[gsa_pkg::IRQ_LOSS_BIT] = loss_evt;
    irq_set[gsa_pkg::IRQ_GAIN_BIT] = gain_evt;
    irq_clr = '0;
    if (wr && addr == gsa_pkg::IRQ_STAT_OFS) begin
      irq_clr = wdata[gsa_pkg::IRQ_W-1:0];
    end
    // A new event in the clearing cycle survives the clear.
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_reg <= gsa_pkg::IRQ_RESET;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_next & irq_mask_reg);
    end
  end

  always_comb begin
    rd_mux = '0;
    case (addr)
      gsa_pkg::CTRL_OFS: begin
        rd_mux[1:0] = ctrl_reg;
      end
      gsa_pkg::STATUS_OFS: begin
        rd_mux[gsa_pkg::STAT_PRESENT_BIT] = present_reg;
        rd_mux[gsa_pkg::STAT_LOCK_BIT] = (align_reg == gsa_pkg::ALN_LOCK);
      end
      gsa_pkg::IRQ_STAT_OFS: begin
        rd_mux[gsa_pkg::IRQ_W-1:0] = irq_stat_reg;
      end
      gsa_pkg::IRQ_MASK_OFS: begin
        rd_mux[gsa_pkg::IRQ_W-1:0] = irq_mask_reg;
      end
      gsa_pkg::RX_WORD_OFS: begin
        rd_mux[gsa_pkg::WORD_W-1:0] = rx_out_reg.word;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data stands for exactly one cycle and is zero otherwise.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= '0;
    end else if (rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign tx_word_clk = tx_word_clk_reg;
  assign dout_p = dout_reg;
  assign dout_n = dout_n_reg;
  assign rx_out = rx_out_reg;
  assign rx_byte_clk0 = rx_clk0_reg;
  assign rx_byte_clk1 = rx_clk1_reg;
  assign signal_present = present_reg;
  assign rdata = rdata_reg;
  assign irq = irq_reg;

endmodule

/* File: verif/gsa_properties.sv */
// Port-level checks for the serial word alignment block.
`timescale 1ns/1ps
module gsa_checker (
  input logic clk,
  input logic nrst,
  input logic din_level_ok,
  input logic dout_p,
  input gsa_pkg::gsa_rx_out_type rx_out,
  input logic rx_byte_clk0,
  input logic rx_byte_clk1,
  input logic signal_present,
  input logic [7:0] addr,
  input logic [31:0] wdata,
  input logic wr,
  input logic rd,
  input logic [31:0] rdata,
  input logic irq
);
  // Shadow copies of the writable fields, rebuilt from bus traffic only.
  logic [1:0] ctrl_reg;
  logic [2:0] mask_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= 2'h0;
      mask_reg <= 3'h0;
    end else if (wr && addr == gsa_pkg::CTRL_OFS) begin
      ctrl_reg <= wdata[1:0];
    end else if (wr && addr == gsa_pkg::IRQ_MASK_OFS) begin
      mask_reg <= wdata[2:0];
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wrap_out_high_a: assert property (ctrl_reg[0] && $past(ctrl_reg[0], 2) |-> dout_p)
    else $error("serial out not high in wrap");
  clk_opposite_a: assert property (rx_byte_clk0 != rx_byte_clk1 |=> rx_byte_clk0 != rx_byte_clk1)
    else $error("byte clocks not opposite");
  align_off_a: assert property (!ctrl_reg[1] && !$past(ctrl_reg[1]) |-> !rx_out.comma_found)
    else $error("comma flag while disabled");
  comma_clk_one_a: assert property ($rose(rx_out.comma_found) |-> $rose(rx_byte_clk1))
    else $error("comma word not on clock one");
  loss_ones_a: assert property (!signal_present && !$past(signal_present, 2)
    |-> rx_out.word == gsa_pkg::RX_ALL_ONES)
    else $error("word not all ones on loss");
  present_rise_a: assert property ($rose(din_level_ok) |-> ##[2:4] signal_present)
    else $error("presence flag late");
  irq_masked_a: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq)
    else $error("irq with all masked");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read");
  ctrl_read_a: assert property ($past(rd) && $past(addr) == gsa_pkg::CTRL_OFS
    |-> rdata == {30'h0, $past(ctrl_reg)})
    else $error("control read wrong");
endmodule
bind gsa_word_align gsa_checker u_chk (.clk, .nrst, .din_level_ok, .dout_p, .rx_out,
  .rx_byte_clk0, .rx_byte_clk1, .signal_present, .addr, .wdata, .wr, .rd, .rdata, .irq);

/* File: verif/gsa_link_far.sv */
// Far side model: host word source and serial line source.
`timescale 1ns/1ps
module gsa_link_far (
  input logic clk,
  input logic tx_word_clk,
  input logic [9:0] host_word,
  input logic [9:0] line_word,
  output logic [9:0] tx_word,
  output logic link_clk,
  output logic din
);
  logic seen = 1'b0;
  logic tx_alt = 1'b0;
  logic line_alt = 1'b0;
  int idx = 0;
  initial begin
    tx_word = 10'h0;
    link_clk = 1'b0;
    din = 1'b0;
    #3;
    forever #62.5 link_clk = ~link_clk;
  end
  // The word moves only after the word clock rose, so it is steady at capture.
  // Every second word goes out inverted, as idle traffic does, so that commas
  // never come back to back and the byte clocks keep alternating.
  always @(posedge clk) begin
    seen <= tx_word_clk;
    if (tx_word_clk && !seen) begin
      tx_word <= tx_alt ? ~host_word : host_word;
      tx_alt <= ~tx_alt;
    end
  end
  // Bits change half a bit away from the sampling rise, bit zero first.
  always @(negedge link_clk) begin
    din <= line_alt ? ~line_word[idx] : line_word[idx];
    idx <= (idx == 9) ? 0 : idx + 1;
    if (idx == 9) begin
      line_alt <= ~line_alt;
    end
  end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the serial word alignment block.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic din_level_ok = 1'b1;
  logic [9:0] host_word = 10'h17c;
  logic [9:0] line_word = 10'h2aa;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic link_clk, din, tx_word_clk, dout_p, dout_n;
  logic rx_byte_clk0, rx_byte_clk1, signal_present, irq;
  logic [9:0] tx_word, exp_w;
  logic [31:0] rdata, rv;
  gsa_pkg::gsa_rx_out_type rx_out;
  int num_errors = 0;
  int n_compared = 0;
  int i, k;
  always #4 clk = ~clk;
  gsa_link_far far (.clk(clk), .tx_word_clk(tx_word_clk), .host_word(host_word),
    .line_word(line_word), .tx_word(tx_word), .link_clk(link_clk), .din(din));
  gsa_word_align dut (.clk(clk), .nrst(nrst), .link_clk(link_clk), .din(din),
    .din_level_ok(din_level_ok), .tx_word(tx_word), .tx_word_clk(tx_word_clk),
    .dout_p(dout_p), .dout_n(dout_n), .rx_out(rx_out), .rx_byte_clk0(rx_byte_clk0),
    .rx_byte_clk1(rx_byte_clk1), .signal_present(signal_present), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  ////////////////////////////////////////
  task final_report;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // Each wait is bounded; running out of cycles ends the run as a failure.
  task wait_for(input int sel, input logic v);
    for (i = 0; i < 4000; i++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? rx_out.comma_found : tx_word_clk) === v) break;
    end
    if (i == 4000) begin
      num_errors++;
      final_report;
    end
  endtask
  task two_commas;
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    chk(rx_out.word === 10'h3ff && rx_out.comma_found === 1'b0, "reset word");
    nrst <= 1'b1;
    rd_reg(8'h20);
    chk(rv === 32'h0, "unmapped read");
    wr_reg(gsa_pkg::IRQ_MASK_OFS, 32'hffffffff);
    rd_reg(gsa_pkg::IRQ_MASK_OFS);
    chk(rv === 32'h7, "mask width");
    wr_reg(gsa_pkg::IRQ_MASK_OFS, 32'h0);
    $display("test registers done");
    wr_reg(gsa_pkg::CTRL_OFS, 32'h3);
    two_commas;
    chk(rx_out.word === 10'h17c && rx_byte_clk1 === 1'b1, "wrapped comma word");
    chk(dout_p === 1'b1 && dout_n === 1'b0, "wrap line level");
    rd_reg(gsa_pkg::RX_WORD_OFS);
    chk(rv === 32'h17c, "received word read");
    $display("test wrap done");
    wr_reg(gsa_pkg::CTRL_OFS, 32'h1);
    repeat (3) @(posedge clk);
    for (k = 0; k < 600; k++) begin
      @(posedge clk);
      #1;
      if (rx_out.comma_found !== 1'b0) break;
    end
    chk(k == 600, "comma flag while disabled");
    $display("test align off done");
    host_word <= 10'h0f3;
    line_word <= 10'h17c;
    wr_reg(gsa_pkg::CTRL_OFS, 32'h2);
    for (k = 0; k < 3; k++) begin
      wait_for(1, 1'b0);
      wait_for(1, 1'b1);
    end
    // The host word still stands one step after the word clock rose.
    exp_w = tx_word;
    repeat (3) @(posedge clk);
    for (k = 0; k < 10; k++) begin
      #1 chk(dout_p === exp_w[k] && dout_n === !exp_w[k], "serial bit");
      @(posedge link_clk);
      repeat (6) @(posedge clk);
    end
    two_commas;
    chk(rx_out.word === 10'h17c, "line comma word");
    $display("test line done");
    wr_reg(gsa_pkg::IRQ_MASK_OFS, 32'h2);
    din_level_ok <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(signal_present === 1'b0 && rx_out.word === 10'h3ff, "loss of input");
    chk(irq === 1'b1, "loss irq");
    rd_reg(gsa_pkg::IRQ_STAT_OFS);
    chk(rv[1] === 1'b1, "loss status");
    wr_reg(gsa_pkg::IRQ_STAT_OFS, 32'h7);
    din_level_ok <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk(irq === 1'b0 && signal_present === 1'b1, "clear and regain");
    rd_reg(gsa_pkg::STATUS_OFS);
    chk(rv[0] === 1'b1, "presence status");
    wr_reg(gsa_pkg::IRQ_MASK_OFS, 32'h4);
    repeat (3) @(posedge clk);
    #1 chk(irq === 1'b1, "gain irq unmasked");
    wr_reg(gsa_pkg::IRQ_MASK_OFS, 32'h0);
    $display("test loss done");
    final_report;
  end
endmodule
